// [design/pfss_pkg.sv]
/*
 * Package for the fault status summary block: command codes, bit
 * positions of the two summary registers, reset values and carriers.
 * Assumes the detailed status registers and the fault detectors live
 * elsewhere and hand over their latched flags as plain vectors.
 */
//
// Overview of operation
// [RL1] Command 78h answers Read Byte with the summary byte, accepts Write Byte.
// [RL2] Low byte of the word and the summary byte are one shared storage.
// [RL3] Summary bits follow detail flags; clearing a detail flag clears its summary.
// [RL4] BUSY bit 7 readable and writable, resets 0, set on busy-declared fault.
// [RL5] Writing 80h to the summary byte clears BUSY if set.
// [RL6] OFF bit 6 is live: 1 when not converting, 0 while converting.
// [RL7] Bit 5 read-only, reset 0, shows an output overvoltage fault.
// [RL8] Bit 4 read-only, reset 0, shows an output overcurrent fault.
// [RL9] Bit 3 read-only, reset 0, shows an input undervoltage fault.
// [RL10] Bit 2 read-only, reset 0, shows any temperature fault or warning.
// [RL11] Bit 1 read-only, reset 0, shows a communication, memory or logic fault.
// [RL12] Bit 0 read-only, reset 0, shows a fault not covered by bits 7 to 1.
// [RL13] Command 79h answers Read Word with two bytes, accepts Write Word.
// [RL14] Word bit 15 read-only, reset 0, shows any output voltage flag.
// [RL15] Word bit 14 read-only, reset 0, shows any output current flag.
// [RL16] Word bit 13 read-only, reset 0, shows any input flag.
// [RL17] Word bit 12 read-only, reset 0, shows any vendor-defined flag.
// [RL18] Word bit 11 live, follows the power-good pin: 1 out of regulation.
// [RL19] Word bit 10 unsupported, always reads 0.
// [RL20] Word bit 9 read-only, reset 0, shows any other-category flag.
// [RL21] Writing 0180h to the word clears BUSY and the unknown bit.
// [RL22] Detail flags clear by clear-faults or by writing 1 in their position.
// [RL23] Each category summary bit (15, 14, 13, 12, 9, 2, 1) is the OR of its detail register flags.
// [RL24] Writes to read-only summary bits are ignored; only BUSY responds.

package pfss_pkg;

    // ************************************************************
    // Command codes
    // ************************************************************
    localparam logic [7:0] CMD_SUMMARY_BYTE = 8'h78;
    localparam logic [7:0] CMD_SUMMARY_WORD = 8'h79;

    // ************************************************************
    // Bit positions in the summary word
    // ************************************************************
    localparam int BIT_BUSY = 7;
    localparam int BIT_OFF = 6;
    localparam int BIT_VOUT_OV = 5;
    localparam int BIT_IOUT_OC = 4;
    localparam int BIT_VIN_UV = 3;
    localparam int BIT_TEMP = 2;
    localparam int BIT_CML = 1;
    localparam int BIT_CATCHALL = 0;
    localparam int BIT_UNKNOWN = 8;
    localparam int BIT_OTHER = 9;
    localparam int BIT_UNSUPPORTED = 10;
    localparam int BIT_PG_N = 11;
    localparam int BIT_VENDOR = 12;
    localparam int BIT_INPUT = 13;
    localparam int BIT_IOUT = 14;
    localparam int BIT_VOUT = 15;

    // Positions of the single flags inside their detail registers
    localparam int DET_VOUT_OVF = 7;
    localparam int DET_IOUT_OCF = 7;
    localparam int DET_VIN_UVF = 4;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [15:0] SUMMARY_RESET = 16'h0000;
    localparam logic [15:0] DATA_RESET = 16'h0000;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic [7:0] code;
        logic write;
        logic [15:0] data;
    } pfss_cmd_t;

    typedef struct packed {
        logic [7:0] vout;
        logic [7:0] iout;
        logic [7:0] input_flags;
        logic [7:0] temp;
        logic [7:0] cml;
        logic [7:0] vendor;
        logic [7:0] other;
    } pfss_detail_t;

endpackage

// [design/pfss_status_summary.sv]
/*
 * Fault status summary registers (byte and word views of one store).
 * The command side runs on the link clock and hands each command to the
 * core clock with a toggle handshake; the answer returns the same way.
 * Assumes detail flags, catch-all fault, busy event and converting come
 * from logic on clk; the power-good pin is asynchronous.
 */
`timescale 1ns/100ps

module pfss_status_summary
(
    // Core clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Link clock and reset
    input wire logic link_clk,
    input wire logic link_reset_n,
    // Command port, link domain
    input wire logic cmd_valid,
    input wire pfss_pkg::pfss_cmd_t cmd,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic rsp_error,
    output logic [15:0] rsp_data,
    // Fault sources, core domain except the asynchronous power-good pin
    input wire pfss_pkg::pfss_detail_t detail,
    input wire logic catchall_fault,
    input wire logic busy_event,
    input wire logic converting,
    input wire logic power_good_output_pin,
    // Live copy of the summary word
    output logic [15:0] fault_summary
);

    // ************************************************************
    // State of both domains
    // ************************************************************
    typedef struct packed {
        logic [15:0] summary;
        logic pg_s1;
        logic pg_s2;
        logic req_s1;
        logic req_s2;
        logic req_s3;
        logic ack_tgl;
        logic [15:0] rd_data;
        logic rd_err;
    } pfss_core_t;

    typedef struct packed {
        logic req_tgl;
        pfss_pkg::pfss_cmd_t held;
        logic pending;
        logic ack_s1;
        logic ack_s2;
        logic ack_s3;
        logic ready;
        logic valid;
        logic err;
        logic [15:0] data;
    } pfss_link_t;

    pfss_core_t core;
    pfss_core_t next_core;
    pfss_link_t lnk;
    pfss_link_t next_lnk;

    logic req_seen;
    logic is_byte;
    logic is_word;
    logic clr_busy;

    // ************************************************************
    // Core domain
    // ************************************************************

    // Request edge and decode; held command is stable while pending
    assign req_seen = core.req_s2 ^ core.req_s3;
    assign is_byte = lnk.held.code == pfss_pkg::CMD_SUMMARY_BYTE;
    assign is_word = lnk.held.code == pfss_pkg::CMD_SUMMARY_WORD;
    // Only the BUSY position reacts to a write; unknown bit is not kept
    assign clr_busy = req_seen && lnk.held.write && (is_byte || is_word)
        && lnk.held.data[pfss_pkg::BIT_BUSY]; // RL5 RL21 RL24

    // Summary recomputed every cycle from its sources
    always_comb
    begin
        next_core = core;
        next_core.pg_s1 = power_good_output_pin;
        next_core.pg_s2 = core.pg_s1;
        next_core.req_s1 = lnk.req_tgl;
        next_core.req_s2 = core.req_s1;
        next_core.req_s3 = core.req_s2;
        // Set beats clear so a busy event in the clearing cycle survives
        next_core.summary[pfss_pkg::BIT_BUSY] = busy_event
            || (core.summary[pfss_pkg::BIT_BUSY] && !clr_busy); // RL4
        next_core.summary[pfss_pkg::BIT_OFF] = !converting; // RL6
        next_core.summary[pfss_pkg::BIT_VOUT_OV] =
            detail.vout[pfss_pkg::DET_VOUT_OVF]; // RL7 RL3 RL22
        next_core.summary[pfss_pkg::BIT_IOUT_OC] =
            detail.iout[pfss_pkg::DET_IOUT_OCF]; // RL8
        next_core.summary[pfss_pkg::BIT_VIN_UV] =
            detail.input_flags[pfss_pkg::DET_VIN_UVF]; // RL9
        next_core.summary[pfss_pkg::BIT_TEMP] = |detail.temp; // RL10 RL23
        next_core.summary[pfss_pkg::BIT_CML] = |detail.cml; // RL11
        next_core.summary[pfss_pkg::BIT_CATCHALL] = catchall_fault; // RL12
        next_core.summary[pfss_pkg::BIT_UNKNOWN] = 1'b0;
        next_core.summary[pfss_pkg::BIT_OTHER] = |detail.other; // RL20
        next_core.summary[pfss_pkg::BIT_UNSUPPORTED] = 1'b0; // RL19
        next_core.summary[pfss_pkg::BIT_PG_N] = core.pg_s2; // RL18
        next_core.summary[pfss_pkg::BIT_VENDOR] = |detail.vendor; // RL17
        next_core.summary[pfss_pkg::BIT_INPUT] = |detail.input_flags; // RL16
        next_core.summary[pfss_pkg::BIT_IOUT] = |detail.iout; // RL15
        next_core.summary[pfss_pkg::BIT_VOUT] = |detail.vout; // RL14
        // Serve one command, then toggle the answer back
        if (req_seen)
        begin
            next_core.ack_tgl = !core.ack_tgl;
            next_core.rd_err = !(is_byte || is_word);
            if (is_byte)
            begin
                // Byte view is the low half of the same store
                next_core.rd_data = {8'h00, core.summary[7:0]}; // RL1 RL2
            end
            else if (is_word)
            begin
                next_core.rd_data = core.summary; // RL13
            end
            else
            begin
                next_core.rd_data = pfss_pkg::DATA_RESET;
            end
        end
    end

    // Core register
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            core <= '{summary: pfss_pkg::SUMMARY_RESET, rd_data: pfss_pkg::DATA_RESET,
                      default: 1'b0};
        end
        else
        begin
            core <= next_core;
        end
    end

    assign fault_summary = core.summary;

    // ************************************************************
    // Link domain
    // ************************************************************

    // One command in flight; ready drops until the answer is back
    always_comb
    begin
        next_lnk = lnk;
        next_lnk.ack_s1 = core.ack_tgl;
        next_lnk.ack_s2 = lnk.ack_s1;
        next_lnk.ack_s3 = lnk.ack_s2;
        next_lnk.valid = 1'b0;
        if (cmd_valid && lnk.ready)
        begin
            next_lnk.held = cmd;
            next_lnk.req_tgl = !lnk.req_tgl;
            next_lnk.pending = 1'b1;
            next_lnk.ready = 1'b0;
        end
        else if (lnk.pending && (lnk.ack_s2 ^ lnk.ack_s3))
        begin
            // Core answer words are stable once the toggle has crossed
            next_lnk.pending = 1'b0;
            next_lnk.ready = 1'b1;
            next_lnk.valid = 1'b1;
            next_lnk.err = core.rd_err;
            next_lnk.data = core.rd_data;
        end
    end

    // Link register
    always_ff @(posedge link_clk)
    begin
        if (!link_reset_n)
        begin
            lnk <= '{ready: 1'b1, data: pfss_pkg::DATA_RESET, held: '0, default: 1'b0};
        end
        else
        begin
            lnk <= next_lnk;
        end
    end

    assign cmd_ready = lnk.ready;
    assign rsp_valid = lnk.valid;
    assign rsp_error = lnk.err;
    assign rsp_data = lnk.data;

    // ************************************************************
    // Assertions
    // ************************************************************

    a_busy_set: assert property (@(posedge clk) disable iff (!reset_n) // RL4
        busy_event |=> fault_summary[pfss_pkg::BIT_BUSY])
        else $error("busy event did not set busy");

    a_busy_clear: assert property (@(posedge clk) disable iff (!reset_n) // RL5
        (clr_busy && !busy_event) |=> !fault_summary[pfss_pkg::BIT_BUSY])
        else $error("busy clear write ignored");

    a_busy_hold: assert property (@(posedge clk) disable iff (!reset_n) // RL24
        (!busy_event && !clr_busy) |=> $stable(fault_summary[pfss_pkg::BIT_BUSY]))
        else $error("busy changed without cause");

    a_off_live: assert property (@(posedge clk) disable iff (!reset_n) // RL6
        ##1 fault_summary[pfss_pkg::BIT_OFF] == !$past(converting))
        else $error("off bit does not track converting");

    a_pg_follow: assert property (@(posedge clk) disable iff (!reset_n) // RL18
        ##3 fault_summary[pfss_pkg::BIT_PG_N] == $past(power_good_output_pin, 3))
        else $error("power good bit lags wrongly");

    a_fixed_zero: assert property (@(posedge clk) disable iff (!reset_n) // RL19
        !fault_summary[pfss_pkg::BIT_UNSUPPORTED] && !fault_summary[pfss_pkg::BIT_UNKNOWN])
        else $error("unsupported bit set");

    a_temp_or: assert property (@(posedge clk) disable iff (!reset_n) // RL10
        ##1 fault_summary[pfss_pkg::BIT_TEMP] == |$past(detail.temp))
        else $error("temperature summary wrong");

    a_vout_or: assert property (@(posedge clk) disable iff (!reset_n) // RL14
        ##1 fault_summary[pfss_pkg::BIT_VOUT] == |$past(detail.vout))
        else $error("voltage summary wrong");

    a_byte_view: assert property (@(posedge clk) disable iff (!reset_n) // RL2
        (req_seen && is_byte) |=> core.rd_data == {8'h00, $past(fault_summary[7:0])})
        else $error("byte read differs from word low byte");

    a_rsp_bound: assert property (@(posedge link_clk) disable iff (!link_reset_n) // RL13
        (cmd_valid && cmd_ready) |-> ##[4:30] rsp_valid)
        else $error("no answer in time");

    // Single-flag bits sit one clock behind their source flag
    a_ovp_follow: assert property (@(posedge clk) disable iff (!reset_n) // RL7
        ##1 fault_summary[pfss_pkg::BIT_VOUT_OV]
            == $past(detail.vout[pfss_pkg::DET_VOUT_OVF]))
        else $error("overvoltage summary wrong");

    a_ocp_follow: assert property (@(posedge clk) disable iff (!reset_n) // RL8
        ##1 fault_summary[pfss_pkg::BIT_IOUT_OC]
            == $past(detail.iout[pfss_pkg::DET_IOUT_OCF]))
        else $error("overcurrent summary wrong");

    a_uvp_follow: assert property (@(posedge clk) disable iff (!reset_n) // RL9
        ##1 fault_summary[pfss_pkg::BIT_VIN_UV]
            == $past(detail.input_flags[pfss_pkg::DET_VIN_UVF]))
        else $error("undervoltage summary wrong");

    a_catchall_follow: assert property (@(posedge clk) disable iff (!reset_n) // RL12
        ##1 fault_summary[pfss_pkg::BIT_CATCHALL]
            == $past(catchall_fault))
        else $error("catch-all summary wrong");

    // Category bits are the OR of the whole detail byte
    a_cml_or: assert property (@(posedge clk) disable iff (!reset_n) // RL11
        ##1 fault_summary[pfss_pkg::BIT_CML]
            == |$past(detail.cml))
        else $error("cml summary wrong");

    a_iout_or: assert property (@(posedge clk) disable iff (!reset_n) // RL15
        ##1 fault_summary[pfss_pkg::BIT_IOUT]
            == |$past(detail.iout))
        else $error("current summary wrong");

    a_input_or: assert property (@(posedge clk) disable iff (!reset_n) // RL16
        ##1 fault_summary[pfss_pkg::BIT_INPUT]
            == |$past(detail.input_flags))
        else $error("input summary wrong");

    a_vendor_or: assert property (@(posedge clk) disable iff (!reset_n) // RL17
        ##1 fault_summary[pfss_pkg::BIT_VENDOR]
            == |$past(detail.vendor))
        else $error("vendor summary wrong");

    a_other_or: assert property (@(posedge clk) disable iff (!reset_n) // RL20
        ##1 fault_summary[pfss_pkg::BIT_OTHER]
            == |$past(detail.other))
        else $error("other summary wrong");

    // A detail flag cleared by the host takes its summary bit along
    a_detail_clear: assert property (@(posedge clk) disable iff (!reset_n) // RL22 RL3
        $fell(detail.vout[pfss_pkg::DET_VOUT_OVF])
            |=> !fault_summary[pfss_pkg::BIT_VOUT_OV])
        else $error("summary kept a cleared detail flag");

    // Reset is watched without disable so the cleared word is seen
    a_reset_clear: assert property (@(posedge clk) // RL4 RL7
        !reset_n
            |=> fault_summary == pfss_pkg::SUMMARY_RESET)
        else $error("summary not cleared by reset");

    // ************************************************************
    // Command path and clock crossing
    // ************************************************************

    // The core answers each request once, from the word before the edge
    a_word_view: assert property (@(posedge clk) disable iff (!reset_n) // RL13
        (req_seen && is_word)
            |=> core.rd_data == $past(fault_summary))
        else $error("word read differs from summary");

    a_bad_code: assert property (@(posedge clk) disable iff (!reset_n) // RL1
        (req_seen && !(is_byte || is_word))
            |=> core.rd_err && (core.rd_data == pfss_pkg::DATA_RESET))
        else $error("unknown code not refused");

    a_req_single: assert property (@(posedge clk) disable iff (!reset_n) // RL1
        req_seen
            |=> !req_seen)
        else $error("one request seen twice");

    a_ack_toggle: assert property (@(posedge clk) disable iff (!reset_n) // RL1
        req_seen
            |=> core.ack_tgl != $past(core.ack_tgl))
        else $error("answer toggle missing");

    a_ack_quiet: assert property (@(posedge clk) disable iff (!reset_n) // RL1
        !req_seen
            |=> $stable(core.ack_tgl))
        else $error("answer toggle without request");

    // Held command must not move while the core may still read it
    a_held_stable: assert property (@(posedge link_clk) disable iff (!link_reset_n) // RL1
        (lnk.pending && $past(lnk.pending))
            |-> $stable(lnk.held))
        else $error("held command changed in flight");

    a_ready_drop: assert property (@(posedge link_clk) disable iff (!link_reset_n) // RL13
        (cmd_valid && cmd_ready)
            |=> !cmd_ready)
        else $error("ready stayed high after a take");

    a_rsp_pulse: assert property (@(posedge link_clk) disable iff (!link_reset_n) // RL13
        rsp_valid
            |=> !rsp_valid)
        else $error("answer pulse too long");

    a_rsp_stands: assert property (@(posedge link_clk) disable iff (!link_reset_n) // RL13
        !rsp_valid
            |-> $stable(rsp_data) && $stable(rsp_error))
        else $error("answer changed between pulses");

    a_answer_copy: assert property (@(posedge link_clk) disable iff (!link_reset_n) // RL13
        (lnk.pending && (lnk.ack_s2 ^ lnk.ack_s3))
            |=> rsp_data == $past(core.rd_data))
        else $error("answer data not the core word");

    a_link_reset: assert property (@(posedge link_clk) // RL13
        !link_reset_n
            |=> cmd_ready && !rsp_valid && !rsp_error)
        else $error("link side not cleared by reset");

    // ************************************************************
    // Cover points
    // ************************************************************

    c_byte_read: cover property (@(posedge clk) disable iff (!reset_n)
        req_seen && is_byte && !lnk.held.write);
    c_word_read: cover property (@(posedge clk) disable iff (!reset_n)
        req_seen && is_word && !lnk.held.write);
    c_busy_clear: cover property (@(posedge clk) disable iff (!reset_n)
        clr_busy && fault_summary[pfss_pkg::BIT_BUSY]);
    c_bad_code: cover property (@(posedge link_clk) disable iff (!link_reset_n)
        rsp_valid && rsp_error);
    c_pg_change: cover property (@(posedge clk) disable iff (!reset_n)
        $changed(fault_summary[pfss_pkg::BIT_PG_N]));

endmodule

// [verif/pfss_host_model.sv]
/* Host model on the summary block command port.
   Assumes a free running link_clk and one command in flight at a time. */
`timescale 1ns/100ps

module pfss_host_model
(
    // Link clock
    input wire logic link_clk,
    // Command port
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    output logic cmd_valid,
    output pfss_pkg::pfss_cmd_t cmd
);
    initial
    begin
        cmd_valid = 1'b0;
        cmd = '0;
    end

    // Offer, hold until taken, then wait for the answer pulse
    task automatic xfer(input logic [7:0] code, input logic wr, input logic [15:0] data);
        int n;
        n = 0;
        @(negedge link_clk);
        cmd_valid = 1'b1;
        cmd = '{code, wr, data};
        @(posedge link_clk);
        while (cmd_ready !== 1'b1 && n < 60)
        begin
            @(posedge link_clk);
            n++;
        end
        @(negedge link_clk);
        cmd_valid = 1'b0;
        cmd = ~cmd; // Released lines must not look like a held command
        while (rsp_valid !== 1'b1 && n < 120)
        begin
            @(posedge link_clk);
            n++;
        end
    endtask
endmodule

// [verif/pfss_status_summary_test.sv]
/* Self-checking bench for the fault status summary registers.
   Assumes the host model above and answers on rsp_valid in order. */
`timescale 1ns/100ps

module pfss_status_summary_test;
    logic clk, link_clk, reset_n, link_reset_n, cmd_valid, cmd_ready;
    logic rsp_valid, rsp_error, catchall_fault, busy_event, converting;
    logic power_good_output_pin, bsy;
    logic [15:0] rsp_data, fault_summary;
    pfss_pkg::pfss_cmd_t cmd;
    pfss_pkg::pfss_detail_t detail;
    logic [16:0] exp_q[$];
    logic [16:0] exp_v;
    int err_total = 0;
    int n_compared = 0;

    // ************************************************************
    // Clocks, instances
    // ************************************************************
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Link clock offset so the two edges never line up
    initial
    begin
        link_clk = 1'b0;
        #3;
        forever #7.5 link_clk = ~link_clk;
    end

    pfss_status_summary uut (.clk(clk), .reset_n(reset_n), .link_clk(link_clk),
        .link_reset_n(link_reset_n), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
        .rsp_data(rsp_data), .detail(detail), .catchall_fault(catchall_fault),
        .busy_event(busy_event), .converting(converting),
        .power_good_output_pin(power_good_output_pin), .fault_summary(fault_summary));

    pfss_host_model host (.link_clk(link_clk), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .cmd_valid(cmd_valid), .cmd(cmd));

    // ************************************************************
    // Model and checks
    // ************************************************************
    function automatic logic [15:0] exp_word();
        return {|detail.vout, |detail.iout, |detail.input_flags, |detail.vendor,
            power_good_output_pin, 1'b0, |detail.other, 1'b0, bsy, ~converting,
            detail.vout[pfss_pkg::DET_VOUT_OVF], detail.iout[pfss_pkg::DET_IOUT_OCF],
            detail.input_flags[pfss_pkg::DET_VIN_UVF], |detail.temp, |detail.cml,
            catchall_fault};
    endfunction

    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Note the answer, send the command; only accepted writes touch BUSY
    task automatic op(input logic [7:0] code, input logic wr, input logic [15:0] data);
        logic ok;
        logic [15:0] w;
        ok = (code == pfss_pkg::CMD_SUMMARY_BYTE) || (code == pfss_pkg::CMD_SUMMARY_WORD);
        w = exp_word();
        exp_v = !ok ? 17'h10000 : (code == pfss_pkg::CMD_SUMMARY_WORD) ?
            {1'b0, w} : {9'h000, w[7:0]};
        exp_q.push_back(exp_v);
        host.xfer(code, wr, data);
        if (ok && wr && data[7])
            bsy = 1'b0;
    endtask

    // Let a source change reach the live word, power-good pin included
    task automatic settle(input logic pulse);
        @(negedge clk);
        busy_event = pulse;
        bsy = bsy | pulse;
        @(negedge clk);
        busy_event = 1'b0;
        repeat (5) @(negedge clk);
        check({1'b0, fault_summary}, {1'b0, exp_word()});
    endtask

    // Each answer pairs with the oldest note
    always @(posedge link_clk)
        if (rsp_valid === 1'b1)
        begin
            exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : {17{1'bx}};
            check({rsp_error, rsp_data}, exp_v);
            check({16'h0000, cmd_ready}, 17'h00001);
        end

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ************************************************************
    // Sequence
    // ************************************************************
    initial
    begin
        void'($urandom(32'hf9af));
        {reset_n, link_reset_n, busy_event, catchall_fault, power_good_output_pin} = '0;
        detail = '0;
        converting = 1'b1;
        bsy = 1'b0;
        repeat (6) @(negedge clk);
        reset_n = 1'b1;
        @(negedge link_clk);
        link_reset_n = 1'b1;
        check({1'b0, fault_summary}, 17'h00000);
        check({rsp_error, rsp_data}, 17'h00000);
        op(8'h78, 1'b0, 16'h0000);
        op(8'h79, 1'b0, 16'h0000);
        // Random sources, random views, writes with BUSY left alone
        repeat (20)
        begin
            @(negedge clk);
            for (int k = 0; k < 7; k++)
                detail[k*8 +: 8] = $urandom_range(1) ? 8'($urandom) : 8'h00;
            {catchall_fault, converting, power_good_output_pin} = 3'($urandom);
            settle(1'($urandom_range(3) == 0));
            op($urandom_range(1) ? 8'h79 : 8'h78, 1'($urandom), 16'($urandom) & 16'hff7f);
        end
        // BUSY set, cleared through the byte, refused, cleared through the word
        settle(1'b1);
        op(8'h78, 1'b1, 16'h0080);
        op(8'h79, 1'b0, 16'h0000);
        settle(1'b1);
        op(8'h79, 1'b1, 16'hff7f);
        op(8'h7a, 1'b1, 16'h0080);
        op(8'h77, 1'b0, 16'h0000);
        op(8'h79, 1'b1, 16'h0180);
        op(8'h78, 1'b0, 16'h0000);
        @(posedge link_clk);
        @(negedge link_clk);
        // A lost answer leaves its note behind
        check(17'(exp_q.size()), 17'h00000);
        print_verdict();
    end

    // Runaway guard, far beyond the expected run of under ten microseconds
    initial
    begin
        #200us;
        err_total++;
        print_verdict();
    end
endmodule
